// file: src/scs_pkg.sv
package scs_pkg;

    // Register byte offsets.
    localparam logic [7:0] SCS_STATUS_OFS = 8'h00;
    localparam logic [7:0] SCS_FLAG_OFS = 8'h04;
    localparam logic [7:0] SCS_MASK_OFS = 8'h08;
    localparam logic [7:0] SCS_CTRL_OFS = 8'h0c;
    localparam logic [7:0] SCS_TRIM_OFS = 8'h10;

    // Field positions.
    localparam int SCS_STATUS_SRC_BIT = 0;
    localparam int SCS_STATUS_BATT_BIT = 1;
    localparam int SCS_FLAG_CHG_BIT = 0;
    localparam int SCS_CTRL_DRV_LSB = 0;
    localparam int SCS_CTRL_KEEP_BIT = 2;
    localparam int SCS_CTRL_CAL_BIT = 3;

    // Reset values.
    localparam logic [1:0] SCS_DRIVE_RESET = 2'h1;
    localparam logic SCS_MASK_RESET = 1'b1;
    localparam logic SCS_KEEP_RESET = 1'b0;
    localparam logic SCS_CAL_RESET = 1'b0;
    localparam logic [4:0] SCS_TRIM_RESET = 5'h00;

    // Timing.
    localparam int SCS_CLK_PERIOD_PS = 4000;
    localparam int SCS_XTAL_LOSS_NS = 100000;
    localparam int SCS_XTAL_LOSS_CYCLES = (SCS_XTAL_LOSS_NS * 1000) / SCS_CLK_PERIOD_PS;
    localparam logic [7:0] SCS_XTAL_GOOD_EDGES = 8'h40;
    localparam logic [16:0] SCS_TICK_NOMINAL = 17'h08000;

    // AXI responses.
    localparam logic [1:0] SCS_RESP_OKAY = 2'h0;
    localparam logic [1:0] SCS_RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        SCS_ST_NONE,
        SCS_ST_RC,
        SCS_ST_TO_XTAL,
        SCS_ST_XTAL,
        SCS_ST_TO_RC
    } scs_state_e;

endpackage : scs_pkg

// file: src/scs_selector.sv
`timescale 1ns/1ps
// Notes on behaviour
// - No crystal running: use internal oscillator.
// - Internal oscillator runs only with main battery.
// - Crystal active: crystal stays selected, never internal.
// - During switch-over end high phase, then park output low, no glitch.
// - Crystal stops: fall back to internal oscillator.
// - Status bit: 0 internal, 1 crystal.
// - Every source change sets change flag, except a switch cut short by battery loss.
// - Flag interrupts only while mask is clear.
// - Control logic clocked from selected slow clock.
// - Crystal and timing logic run without battery.
// - 1 Hz tick from calibratable 32768 counter.
// - Two-bit output drive select, resets to 01.
// - Secondary slow clock output for secure keeper.
// - Keep-on bit keeps secondary output enabled.
// - Five-bit signed trim corrects counter only.
module scs_selector #(
    parameter int XTAL_LOSS_CYCLES = scs_pkg::SCS_XTAL_LOSS_CYCLES
) (
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // Oscillator and supply inputs.
    input wire logic crystal_clk_in,
    input wire logic rc_clk_in,
    input wire logic main_battery_supply,
    input wire logic device_off_state,
    // Oscillator and clock outputs.
    output logic rc_osc_enable,
    output logic main_slow_clock_out,
    output logic processor_slow_clock_out,
    output logic processor_slow_clock_oe,
    output logic [1:0] slow_out_drive_select,
    output logic slow_clock_enable,
    output logic one_hz_tick,
    output logic irq,
    // AXI4-Lite write address.
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data.
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response.
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address.
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data.
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import scs_pkg::*;

    localparam logic [15:0] LOSS_LIMIT = 16'(XTAL_LOSS_CYCLES);

    function automatic logic reg_mapped(input logic [7:0] addr);
        reg_mapped = (addr == SCS_STATUS_OFS) || (addr == SCS_FLAG_OFS) ||
                     (addr == SCS_MASK_OFS) || (addr == SCS_CTRL_OFS) ||
                     (addr == SCS_TRIM_OFS);
    endfunction : reg_mapped

    // Oscillator observation and source selection state.
    logic xtal_prev;
    logic rc_prev;
    logic sel_prev;
    logic [15:0] loss_cnt;
    logic [7:0] good_cnt;
    logic xtal_running;
    scs_state_e state;
    logic src_status;
    logic src_status_sync;
    logic [16:0] tick_cnt;
    logic next_xtal_prev;
    logic next_rc_prev;
    logic next_sel_prev;
    logic [15:0] next_loss_cnt;
    logic [7:0] next_good_cnt;
    logic next_xtal_running;
    scs_state_e next_state;
    logic next_src_status;
    logic next_src_status_sync;
    logic [16:0] next_tick_cnt;
    logic next_main_out;
    logic next_mcu_out;
    logic next_mcu_oe;
    logic next_rc_enable;
    logic next_slow_en;
    logic next_tick;
    logic change_event;

    // Register file and bus state.
    logic change_flag;
    logic change_mask;
    logic keep_on;
    logic cal_enable;
    logic [4:0] trim_word;
    logic aw_full;
    logic w_full;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic next_change_flag;
    logic next_change_mask;
    logic next_keep_on;
    logic next_cal_enable;
    logic [4:0] next_trim_word;
    logic [1:0] next_drive;
    logic next_aw_full;
    logic next_w_full;
    logic [7:0] next_aw_addr;
    logic [31:0] next_w_data;
    logic [3:0] next_w_strb;
    logic next_awready;
    logic next_wready;
    logic next_bvalid;
    logic [1:0] next_bresp;
    logic next_arready;
    logic next_rvalid;
    logic [31:0] next_rdata;
    logic [1:0] next_rresp;
    logic next_irq;

    always_comb
    begin
        logic xtal_rise;
        logic sel_level;
        logic sel_rise;
        logic [16:0] terminal;
        logic park_level;
        xtal_rise = crystal_clk_in && !xtal_prev;
        // Between sources a high phase is kept two cycles at most and then parked low,
        // so a switch can neither leave a runt nor wait forever on a held high.
        park_level = main_slow_clock_out && !sel_prev;
        sel_level = park_level;
        sel_rise = 1'b0;
        terminal = SCS_TICK_NOMINAL;
        next_xtal_prev = crystal_clk_in;
        next_rc_prev = rc_clk_in;
        next_loss_cnt = loss_cnt;
        next_good_cnt = good_cnt;
        next_xtal_running = xtal_running;
        next_state = state;
        change_event = 1'b0;
        // The crystal watchdog runs on every edge whatever the battery does.
        if (xtal_rise)
        begin
            next_loss_cnt = 16'h0000;
            if (good_cnt != SCS_XTAL_GOOD_EDGES)
            begin
                next_good_cnt = good_cnt + 8'h01;
            end
            else
            begin
                next_xtal_running = 1'b1;
            end
        end
        else if (loss_cnt >= LOSS_LIMIT)
        begin
            // A silent crystal must requalify before it can be picked again.
            next_xtal_running = 1'b0;
            next_good_cnt = 8'h00;
        end
        else
        begin
            next_loss_cnt = loss_cnt + 16'h0001;
        end
        // The output is parked low during a switch and released only when both the
        // parked level and the new source are low, so no runt pulse escapes.
        case (state)
            SCS_ST_NONE:
            begin
                if (xtal_running)
                begin
                    next_state = SCS_ST_TO_XTAL;
                end
                else if (main_battery_supply)
                begin
                    next_state = SCS_ST_TO_RC;
                end
            end
            SCS_ST_RC:
            begin
                sel_level = rc_clk_in;
                sel_rise = rc_clk_in && !rc_prev;
                if (xtal_running)
                begin
                    next_state = SCS_ST_TO_XTAL;
                end
                else if (!main_battery_supply)
                begin
                    next_state = SCS_ST_NONE;
                    change_event = 1'b1;
                end
            end
            SCS_ST_TO_XTAL:
            begin
                if (!xtal_running)
                begin
                    next_state = main_battery_supply ? SCS_ST_TO_RC : SCS_ST_NONE;
                end
                else if (!main_slow_clock_out && !crystal_clk_in)
                begin
                    next_state = SCS_ST_XTAL;
                    change_event = 1'b1;
                end
            end
            SCS_ST_XTAL:
            begin
                // The internal oscillator is never looked at here.
                sel_level = crystal_clk_in;
                sel_rise = xtal_rise;
                if (!xtal_running)
                begin
                    next_state = main_battery_supply ? SCS_ST_TO_RC : SCS_ST_NONE;
                    change_event = !main_battery_supply;
                end
            end
            SCS_ST_TO_RC:
            begin
                if (xtal_running)
                begin
                    next_state = SCS_ST_TO_XTAL;
                end
                else if (!main_battery_supply)
                begin
                    next_state = SCS_ST_NONE;
                end
                else if (!main_slow_clock_out && !rc_clk_in)
                begin
                    next_state = SCS_ST_RC;
                    change_event = 1'b1;
                end
            end
            default:
            begin
                next_state = SCS_ST_NONE;
            end
        endcase
        next_main_out = sel_level;
        next_sel_prev = main_slow_clock_out;
        // Control logic downstream runs on this enable, one pulse per rising slow edge.
        next_slow_en = sel_rise;
        next_src_status = (state == SCS_ST_XTAL);
        next_src_status_sync = src_status;
        next_rc_enable = main_battery_supply;
        // Secondary output follows the selected clock; drive in off state only on keep-on.
        next_mcu_oe = keep_on || !device_off_state;
        next_mcu_out = next_mcu_oe && sel_level;
        // Trim shortens or stretches the second, never the clocks themselves.
        if (cal_enable)
        begin
            terminal = SCS_TICK_NOMINAL - {{12{trim_word[4]}}, trim_word};
        end
        next_tick = 1'b0;
        next_tick_cnt = tick_cnt;
        if (sel_rise)
        begin
            if (tick_cnt + 17'h00001 >= terminal)
            begin
                next_tick_cnt = 17'h00000;
                next_tick = 1'b1;
            end
            else
            begin
                next_tick_cnt = tick_cnt + 17'h00001;
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            xtal_prev <= 1'b0;
            rc_prev <= 1'b0;
            sel_prev <= 1'b0;
            loss_cnt <= 16'h0000;
            good_cnt <= 8'h00;
            xtal_running <= 1'b0;
            state <= SCS_ST_NONE;
            src_status <= 1'b0;
            src_status_sync <= 1'b0;
            tick_cnt <= 17'h00000;
            main_slow_clock_out <= 1'b0;
            processor_slow_clock_out <= 1'b0;
            processor_slow_clock_oe <= 1'b0;
            rc_osc_enable <= 1'b0;
            slow_clock_enable <= 1'b0;
            one_hz_tick <= 1'b0;
        end
        else
        begin
            xtal_prev <= next_xtal_prev;
            rc_prev <= next_rc_prev;
            sel_prev <= next_sel_prev;
            loss_cnt <= next_loss_cnt;
            good_cnt <= next_good_cnt;
            xtal_running <= next_xtal_running;
            state <= next_state;
            src_status <= next_src_status;
            src_status_sync <= next_src_status_sync;
            tick_cnt <= next_tick_cnt;
            main_slow_clock_out <= next_main_out;
            processor_slow_clock_out <= next_mcu_out;
            processor_slow_clock_oe <= next_mcu_oe;
            rc_osc_enable <= next_rc_enable;
            slow_clock_enable <= next_slow_en;
            one_hz_tick <= next_tick;
        end
    end

    // Bus slave and register file.
    always_comb
    begin
        logic do_write;
        logic do_read;
        do_write = aw_full && w_full && !s_axi_bvalid;
        do_read = s_axi_arvalid && s_axi_arready;
        next_aw_full = aw_full;
        next_w_full = w_full;
        next_aw_addr = aw_addr;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_bvalid = s_axi_bvalid && !s_axi_bready;
        next_bresp = s_axi_bresp;
        next_rvalid = s_axi_rvalid && !s_axi_rready;
        next_rdata = s_axi_rdata;
        next_rresp = s_axi_rresp;
        next_change_mask = change_mask;
        next_keep_on = keep_on;
        next_cal_enable = cal_enable;
        next_trim_word = trim_word;
        next_drive = slow_out_drive_select;
        next_change_flag = change_flag;
        if (s_axi_awvalid && s_axi_awready)
        begin
            next_aw_full = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            next_w_full = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        if (do_write)
        begin
            next_aw_full = 1'b0;
            next_w_full = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = reg_mapped(aw_addr) ? SCS_RESP_OKAY : SCS_RESP_SLVERR;
            if (w_strb[0])
            begin
                case (aw_addr)
                    SCS_FLAG_OFS:
                    begin
                        if (w_data[SCS_FLAG_CHG_BIT])
                        begin
                            next_change_flag = 1'b0;
                        end
                    end
                    SCS_MASK_OFS:
                    begin
                        next_change_mask = w_data[SCS_FLAG_CHG_BIT];
                    end
                    SCS_CTRL_OFS:
                    begin
                        next_drive = w_data[SCS_CTRL_DRV_LSB +: 2];
                        next_keep_on = w_data[SCS_CTRL_KEEP_BIT];
                        next_cal_enable = w_data[SCS_CTRL_CAL_BIT];
                    end
                    SCS_TRIM_OFS:
                    begin
                        next_trim_word = w_data[4:0];
                    end
                    default:
                    begin
                        next_drive = slow_out_drive_select;
                    end
                endcase
            end
        end
        // A change in the same cycle as a clear still leaves the flag set.
        if (change_event)
        begin
            next_change_flag = 1'b1;
        end
        if (do_read)
        begin
            next_rvalid = 1'b1;
            next_rresp = reg_mapped(s_axi_araddr) ? SCS_RESP_OKAY : SCS_RESP_SLVERR;
            next_rdata = 32'h00000000;
            case (s_axi_araddr)
                SCS_STATUS_OFS:
                begin
                    next_rdata[SCS_STATUS_SRC_BIT] = src_status_sync;
                    next_rdata[SCS_STATUS_BATT_BIT] = rc_osc_enable;
                end
                SCS_FLAG_OFS:
                begin
                    next_rdata[SCS_FLAG_CHG_BIT] = change_flag;
                end
                SCS_MASK_OFS:
                begin
                    next_rdata[SCS_FLAG_CHG_BIT] = change_mask;
                end
                SCS_CTRL_OFS:
                begin
                    next_rdata[SCS_CTRL_DRV_LSB +: 2] = slow_out_drive_select;
                    next_rdata[SCS_CTRL_KEEP_BIT] = keep_on;
                    next_rdata[SCS_CTRL_CAL_BIT] = cal_enable;
                end
                SCS_TRIM_OFS:
                begin
                    next_rdata[4:0] = trim_word;
                end
                default:
                begin
                    next_rdata = 32'h00000000;
                end
            endcase
        end
        next_awready = !next_aw_full;
        next_wready = !next_w_full;
        next_arready = !next_rvalid;
        next_irq = next_change_flag && !next_change_mask;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_full <= 1'b0;
            w_full <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= SCS_RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= SCS_RESP_OKAY;
            change_flag <= 1'b0;
            change_mask <= SCS_MASK_RESET;
            keep_on <= SCS_KEEP_RESET;
            cal_enable <= SCS_CAL_RESET;
            trim_word <= SCS_TRIM_RESET;
            slow_out_drive_select <= SCS_DRIVE_RESET;
            irq <= 1'b0;
        end
        else
        begin
            aw_full <= next_aw_full;
            w_full <= next_w_full;
            aw_addr <= next_aw_addr;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            s_axi_awready <= next_awready;
            s_axi_wready <= next_wready;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp <= next_bresp;
            s_axi_arready <= next_arready;
            s_axi_rvalid <= next_rvalid;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= next_rresp;
            change_flag <= next_change_flag;
            change_mask <= next_change_mask;
            keep_on <= next_keep_on;
            cal_enable <= next_cal_enable;
            trim_word <= next_trim_word;
            slow_out_drive_select <= next_drive;
            irq <= next_irq;
        end
    end

endmodule : scs_selector

// file: bench/scs_selector_checker.sv
`timescale 1ns/1ps
module scs_selector_checker #(
    parameter int XTAL_LOSS_CYCLES = 50
) (
    // Clock, reset and levels.
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic main_battery_supply,
    input wire logic device_off_state,
    // Clock outputs and events.
    input wire logic rc_osc_enable,
    input wire logic main_slow_clock_out,
    input wire logic processor_slow_clock_out,
    input wire logic processor_slow_clock_oe,
    input wire logic [1:0] slow_out_drive_select,
    input wire logic slow_clock_enable,
    input wire logic one_hz_tick,
    input wire logic irq,
    // Bus handshakes.
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    batt_gate_a: assert property (!main_battery_supply |=> !rc_osc_enable)
        else $error("RC oscillator enabled without battery");
    drive_reset_a: assert property ($rose(aresetn) |-> slow_out_drive_select == 2'h1)
        else $error("Drive select not 01 after reset");
    high_width_a: assert property ($rose(main_slow_clock_out) |=> main_slow_clock_out)
        else $error("Runt high pulse on slow clock");
    low_width_a: assert property ($fell(main_slow_clock_out) |=> !main_slow_clock_out)
        else $error("Runt low pulse on slow clock");
    enable_pulse_a: assert property (slow_clock_enable |=> !slow_clock_enable)
        else $error("Slow clock enable longer than one cycle");
    tick_pulse_a: assert property (one_hz_tick |=> !one_hz_tick)
        else $error("Second tick longer than one cycle");
    oe_on_a: assert property (!device_off_state [*3] |-> processor_slow_clock_oe)
        else $error("Secondary driver off outside off state");
    oe_quiet_a: assert property (!processor_slow_clock_oe |-> !processor_slow_clock_out)
        else $error("Secondary clock toggles while disabled");
    irq_fall_a: assert property ($fell(irq) |-> $rose(s_axi_bvalid) || $fell(s_axi_bvalid))
        else $error("Interrupt dropped without a write");
    read_lat_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("Read data late");
    read_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("Read data held after acceptance");

    irq_set_c: cover property ($rose(irq));
    oe_off_c: cover property (device_off_state && !processor_slow_clock_oe);
    src_edge_c: cover property (slow_clock_enable);
endmodule : scs_selector_checker

bind scs_selector scs_selector_checker #(.XTAL_LOSS_CYCLES(XTAL_LOSS_CYCLES)) chk (.*);

// file: bench/scs_osc_model.sv
`timescale 1ns/1ps
module scs_osc_model #(
    parameter int XTAL_HALF = 3,
    parameter int RC_HALF = 4
) (
    // Clock and controls.
    input wire logic aclk,
    input wire logic crystal_running,
    input wire logic rc_osc_enable,
    // Oscillator levels.
    output logic crystal_clk_in,
    output logic rc_clk_in
);
    int xc = 0;
    int rc = 0;

    initial
    begin
        crystal_clk_in = 1'b0;
        rc_clk_in = 1'b0;
    end

    // A stopped oscillator ends its high phase, then stands low, so it makes no runt.
    // The crystal runs from the coin cell whether the battery is there or not.
    always @(posedge aclk)
    begin
        if (crystal_running || crystal_clk_in)
        begin
            xc <= (xc == XTAL_HALF - 1) ? 0 : xc + 1;
            if (xc == XTAL_HALF - 1)
                crystal_clk_in <= ~crystal_clk_in;
        end
    end

    // The backup oscillator runs only while the device enables it.
    always @(posedge aclk)
    begin
        if (rc_osc_enable || rc_clk_in)
        begin
            rc <= (rc == RC_HALF - 1) ? 0 : rc + 1;
            if (rc == RC_HALF - 1)
                rc_clk_in <= ~rc_clk_in;
        end
    end
endmodule : scs_osc_model

// file: bench/slow_clock_source_selector_tb.sv
`timescale 1ns/1ps
`define CHK(got, exp) \
    begin \
        tests_run++; \
        if ((got) !== (exp)) \
        begin \
            $display("Error at %0t: got %0h, expected %0h", $time, got, exp); \
            n_errors++; \
        end \
    end

module slow_clock_source_selector_tb;
    import scs_pkg::*;
    logic aclk, aresetn, main_battery_supply, device_off_state, crystal_running;
    logic crystal_clk_in, rc_clk_in, rc_osc_enable, main_slow_clock_out, irq;
    logic processor_slow_clock_out, processor_slow_clock_oe, slow_clock_enable, one_hz_tick;
    logic [1:0] slow_out_drive_select, s_axi_bresp, s_axi_rresp, rr;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rdv;
    logic [3:0] s_axi_wstrb;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    int n_errors = 0;
    int tests_run = 0;
    int cycles = 0;

    scs_selector #(.XTAL_LOSS_CYCLES(50)) dut (.*);
    scs_osc_model osc (.*);

    initial
    begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end

    task automatic print_verdict;
        $display("Comparisons %0d, mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : print_verdict

    always @(posedge aclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_errors++;
            $display("Error at %0t: run timed out", $time);
            print_verdict();
        end
    end

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end while (!(s_axi_bvalid && s_axi_bready));
        `CHK(s_axi_bresp, er)
        s_axi_bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end while (!(s_axi_rvalid && s_axi_rready));
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : rd

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        rd(a, rdv, rr);
        `CHK(rr, SCS_RESP_OKAY)
        `CHK(rdv, e)
    endtask : rd_chk

    // Polls the change flag; a flag that never comes shows up in the caller's compare.
    task automatic wait_flag;
        int i;
        i = 0;
        do
        begin
            rd(SCS_FLAG_OFS, rdv, rr);
            i++;
        end while (rdv[0] !== 1'b1 && i < 300);
    endtask : wait_flag

    initial
    begin
        {aresetn, device_off_state, crystal_running, s_axi_awvalid, s_axi_wvalid} = '0;
        {s_axi_bready, s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hf;
        main_battery_supply = 1'b1;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        #1;
        `CHK(slow_out_drive_select, SCS_DRIVE_RESET)
        rd_chk(SCS_MASK_OFS, 32'h1);
        rd_chk(SCS_CTRL_OFS, 32'h1);
        rd_chk(SCS_TRIM_OFS, 32'h0);
        rd(8'h14, rdv, rr);
        `CHK(rr, SCS_RESP_SLVERR)
        `CHK(rdv, 32'h0)
        $display("Test reset values done");
        wait_flag();
        rd_chk(SCS_STATUS_OFS, 32'h2);
        `CHK(irq, 1'b0)
        wr(SCS_MASK_OFS, 32'h0, SCS_RESP_OKAY);
        repeat (3) @(posedge aclk);
        `CHK(irq, 1'b1)
        wr(SCS_FLAG_OFS, 32'h1, SCS_RESP_OKAY);
        repeat (3) @(posedge aclk);
        `CHK(irq, 1'b0)
        rd_chk(SCS_FLAG_OFS, 32'h0);
        $display("Test backup source done");
        crystal_running <= 1'b1;
        wait_flag();
        rd_chk(SCS_STATUS_OFS, 32'h3);
        `CHK(irq, 1'b1)
        wr(SCS_FLAG_OFS, 32'h1, SCS_RESP_OKAY);
        main_battery_supply <= 1'b0;
        repeat (200) @(posedge aclk);
        rd_chk(SCS_STATUS_OFS, 32'h1);
        rd_chk(SCS_FLAG_OFS, 32'h0);
        `CHK(rc_osc_enable, 1'b0)
        main_battery_supply <= 1'b1;
        repeat (50) @(posedge aclk);
        rd_chk(SCS_FLAG_OFS, 32'h0);
        crystal_running <= 1'b0;
        wait_flag();
        rd_chk(SCS_STATUS_OFS, 32'h2);
        wr(SCS_FLAG_OFS, 32'h1, SCS_RESP_OKAY);
        $display("Test crystal start and loss done");
        main_battery_supply <= 1'b0;
        wait_flag();
        rd_chk(SCS_STATUS_OFS, 32'h0);
        `CHK(rc_osc_enable, 1'b0)
        `CHK(main_slow_clock_out, 1'b0)
        wr(SCS_FLAG_OFS, 32'h1, SCS_RESP_OKAY);
        main_battery_supply <= 1'b1;
        wait_flag();
        rd_chk(SCS_STATUS_OFS, 32'h2);
        wr(SCS_FLAG_OFS, 32'h1, SCS_RESP_OKAY);
        $display("Test battery loss done");
        for (int i = 0; i < 4; i++)
        begin
            wr(SCS_CTRL_OFS, 32'(i), SCS_RESP_OKAY);
            repeat (3) @(posedge aclk);
            `CHK(slow_out_drive_select, 2'(i))
            rd_chk(SCS_CTRL_OFS, 32'(i));
        end
        device_off_state <= 1'b1;
        repeat (3) @(posedge aclk);
        `CHK(processor_slow_clock_oe, 1'b0)
        `CHK(processor_slow_clock_out, 1'b0)
        wr(SCS_CTRL_OFS, 32'hd, SCS_RESP_OKAY);
        repeat (3) @(posedge aclk);
        `CHK(processor_slow_clock_oe, 1'b1)
        rd_chk(SCS_CTRL_OFS, 32'hd);
        device_off_state <= 1'b0;
        $display("Test output control done");
        wr(SCS_TRIM_OFS, 32'h10, SCS_RESP_OKAY);
        rd_chk(SCS_TRIM_OFS, 32'h10);
        wr(SCS_TRIM_OFS, 32'hff, SCS_RESP_OKAY);
        rd_chk(SCS_TRIM_OFS, 32'h1f);
        wr(8'h14, 32'h1, SCS_RESP_SLVERR);
        rd_chk(SCS_MASK_OFS, 32'h0);
        $display("Test trim and unmapped done");
        print_verdict();
    end
endmodule : slow_clock_source_selector_tb
